// ===== see_defs.vh
// constants for the two-wire serial memory slave
`ifndef SEE_DEFS_VH
`define SEE_DEFS_VH
`define SEE_DEV_ID 7'h50
`define SEE_MEM_DEPTH 128
`define SEE_ADDR_W 7
`define SEE_PAGE_W 3
`define SEE_FIFO_DEPTH 8
`define SEE_FIFO_AW 3
`define SEE_BIT_LAST 4'h7
`define SEE_BIT_ACK 4'h8
`define SEE_CLK_NS 8
`define SEE_PROG_US 5
`define SEE_PROG_CYC ((`SEE_PROG_US * 1000) / `SEE_CLK_NS)
`endif

// ===== see_fifo.v
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module see_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	// clock and reset
	input wire sys_clk,
	input wire sys_rst,
	// fill side
	input wire inValid,
	output wire inReady,
	input wire [WIDTH-1:0] inData,
	// drain side
	output wire outValid,
	input wire outReady,
	output wire [WIDTH-1:0] outData
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW:0] wrPtr_ff;
	reg [AW:0] rdPtr_ff;
	wire [AW:0] fill = wrPtr_ff - rdPtr_ff;
	wire doWr = inValid && inReady;
	wire doRd = outValid && outReady;
	assign inReady = (fill != DEPTH[AW:0]);
	assign outValid = (fill != {(AW+1){1'b0}});
	assign outData = mem[rdPtr_ff[AW-1:0]];
	always @(posedge sys_clk) begin
		if (doWr)
			mem[wrPtr_ff[AW-1:0]] <= inData;
	end
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			wrPtr_ff <= {(AW+1){1'b0}};
			rdPtr_ff <= {(AW+1){1'b0}};
		end else begin
			if (doWr)
				wrPtr_ff <= wrPtr_ff + 1'b1;
			if (doRd)
				rdPtr_ff <= rdPtr_ff + 1'b1;
		end
	end
endmodule

// ===== see_master_model.sv
// two-wire bus master model
`timescale 1ns/1ps
module see_master_model (
	// bus lines
	input wire logic sdaLine,
	output logic scl,
	output logic sda
);
	initial begin
		scl = 1'b1;
		sda = 1'b1;
	end
	// start or repeated start; clock stands high between frames
	task automatic start();
		sda <= 1'b1;
		#16 scl <= 1'b1;
		#32 sda <= 1'b0;
		#32 scl <= 1'b0;
		#16;
	endtask
	task automatic stop();
		sda <= 1'b0;
		#16 scl <= 1'b1;
		#32 sda <= 1'b1;
		#32;
	endtask
	// data set mid low half, sampled late in high half
	task automatic clk1(input logic b, output logic r);
		sda <= b;
		#16 scl <= 1'b1;
		#28 r = sdaLine;
		#4 scl <= 1'b0;
		#16;
	endtask
	task automatic tx(input logic [7:0] d, output logic r);
		for (int i = 7; i >= 0; i--) clk1(d[i], r);
		clk1(1'b1, r);
	endtask
	task automatic rx(input logic ack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) clk1(1'b1, d[i]);
		clk1(ack, r);
	endtask
endmodule

// ===== see_mem.v
// 128 byte storage array with registered read data
`timescale 1ns/1ps
`include "see_defs.vh"
module see_mem (
	// clock
	input wire sys_clk,
	// write port
	input wire wrEn,
	input wire [`SEE_ADDR_W-1:0] wrAddr,
	input wire [7:0] wrData,
	// read port
	input wire [`SEE_ADDR_W-1:0] rdAddr,
	output reg [7:0] rdData
);
	reg [7:0] mem [0:`SEE_MEM_DEPTH-1];
	always @(posedge sys_clk) begin
		if (wrEn)
			mem[wrAddr] <= wrData;
		rdData <= mem[rdAddr];
	end
endmodule

// ===== see_slave.v
// two-wire serial memory slave: protocol engine and write cycle timer
`timescale 1ns/1ps
`include "see_defs.vh"
// Function
// - acknowledge word address before data byte
// - ack low after address and data
// - stop starts timed programming, bus ignored
// - no ack to write address while busy
// - current, random and sequential reads supported
// - address counter holds last plus one
// - read wraps array end to zero
// - write wraps within current page
// - read address ack, then shift byte
// - random read returns dummy-loaded address byte
// - master ack continues next byte
// - sequential read wraps without pause
// - device byte 1010 000 plus direction
// - start and stop only with scl high
// - eight bits then ack on ninth
// - 128 bytes, 7-bit word address
module see_slave (
	// clock and reset
	input wire sys_clk,
	input wire sys_rst,
	// two-wire pins
	input wire sclIn,
	input wire sdaIn,
	output reg sdaOut_ff,
	output reg sdaOe_ff,
	// status
	output reg busy_ff,
	output reg selected_ff
);
	localparam ST_IDLE = 7'b0000001;
	localparam ST_DEV = 7'b0000010;
	localparam ST_WADR = 7'b0000100;
	localparam ST_WDAT = 7'b0001000;
	localparam ST_RD = 7'b0010000;
	localparam ST_RACK = 7'b0100000;
	localparam ST_HOLD = 7'b1000000;

	reg [6:0] state_ff;
	reg [3:0] bitCnt_ff;
	reg [7:0] shift_ff;
	reg [`SEE_ADDR_W-1:0] addr_ff;
	reg ackPhase_ff;
	reg readDir_ff;
	reg pendWr_ff;
	reg [7:0] pendData_ff;
	reg [`SEE_ADDR_W-1:0] pendAddr_ff;
	reg [15:0] progCnt_ff;
	reg [7:0] txByte_ff;

	// two-stage synchronisers per pin, first stage read only by second
	// reset to the idle bus level so no false edge follows reset
	wire [1:0] pinIn;
	wire [1:0] pinSync;
	wire [1:0] pinDly;
	assign pinIn = {sdaIn, sclIn};
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
			reg meta_ff;
			reg sync_ff;
			reg dly_ff;
			always @(posedge sys_clk) begin
				if (sys_rst) begin
					meta_ff <= 1'b1;
					sync_ff <= 1'b1;
					dly_ff <= 1'b1;
				end else begin
					meta_ff <= pinIn[gi];
					sync_ff <= meta_ff;
					dly_ff <= sync_ff;
				end
			end
			assign pinSync[gi] = sync_ff;
			assign pinDly[gi] = dly_ff;
		end
	endgenerate

	wire sclSync;
	wire sclDly;
	wire sdaSync;
	wire sdaDly;
	wire sclRise;
	wire sclFall;
	wire startCond;
	wire stopCond;
	wire [7:0] rxByte;
	wire devMatch;
	wire rxStep;
	wire byteDone;
	wire ackDone;
	assign sclSync = pinSync[0];
	assign sclDly = pinDly[0];
	assign sdaSync = pinSync[1];
	assign sdaDly = pinDly[1];
	assign sclRise = sclSync && !sclDly;
	assign sclFall = !sclSync && sclDly;
	// sda edges count as start or stop only with scl high on both samples
	assign startCond = sclSync && sclDly && sdaDly && !sdaSync;
	assign stopCond = sclSync && sclDly && !sdaDly && sdaSync;
	assign rxByte = {shift_ff[6:0], sdaSync};
	assign devMatch = (shift_ff[7:1] == `SEE_DEV_ID);
	// bits shift in on rising scl outside the ack slot
	assign rxStep = sclRise && !ackPhase_ff;
	// ack slot opens on the fall after bit 8, closes on the next fall
	assign byteDone = sclFall && !ackPhase_ff && bitCnt_ff == `SEE_BIT_ACK;
	assign ackDone = sclFall && ackPhase_ff;

	// memory read data and write path through the fifo
	wire [7:0] memRdData;
	wire fifoInReady;
	wire fifoOutValid;
	wire [14:0] fifoOutData;
	wire fifoPush;
	wire commitWr;
	// a byte is queued only when a stop closes a complete write
	assign fifoPush = stopCond && pendWr_ff && !busy_ff;
	assign commitWr = fifoOutValid && !busy_ff;

	see_fifo #(
		.WIDTH(15),
		.DEPTH(`SEE_FIFO_DEPTH),
		.AW(`SEE_FIFO_AW)
	) u_fifo (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.inValid(fifoPush),
		.inReady(fifoInReady),
		.inData({pendAddr_ff, pendData_ff}),
		.outValid(fifoOutValid),
		.outReady(commitWr),
		.outData(fifoOutData)
	);

	see_mem u_mem (
		.sys_clk(sys_clk),
		.wrEn(commitWr),
		.wrAddr(fifoOutData[14:8]),
		.wrData(fifoOutData[7:0]),
		.rdAddr(addr_ff),
		.rdData(memRdData)
	);

	// programming cycle timer
	wire [31:0] progLoad;
	reg nxt_busy;
	reg [15:0] nxt_progCnt;
	assign progLoad = `SEE_PROG_CYC - 1;
	always @* begin
		nxt_busy = busy_ff;
		nxt_progCnt = progCnt_ff;
		if (commitWr) begin
			nxt_busy = 1'b1;
			nxt_progCnt = progLoad[15:0];
		end else if (busy_ff) begin
			if (progCnt_ff == 16'h0000)
				nxt_busy = 1'b0;
			else
				nxt_progCnt = progCnt_ff - 16'h0001;
		end
	end
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			busy_ff <= 1'b0;
			progCnt_ff <= 16'h0000;
		end else begin
			busy_ff <= nxt_busy;
			progCnt_ff <= nxt_progCnt;
		end
	end

	// page wrap for write increment
	wire [`SEE_ADDR_W-1:0] wrNext;
	wire [`SEE_ADDR_W-1:0] rdNext;
	assign wrNext = {addr_ff[`SEE_ADDR_W-1:`SEE_PAGE_W],
		addr_ff[`SEE_PAGE_W-1:0] + 3'h1};
	// read increment rolls over the whole array
	assign rdNext = addr_ff + 7'h01;

	// protocol engine
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			state_ff <= ST_IDLE;
			bitCnt_ff <= 4'h0;
			shift_ff <= 8'h00;
			ackPhase_ff <= 1'b0;
			readDir_ff <= 1'b0;
			sdaOut_ff <= 1'b0;
			sdaOe_ff <= 1'b0;
			selected_ff <= 1'b0;
			pendWr_ff <= 1'b0;
			pendData_ff <= 8'h00;
			pendAddr_ff <= {`SEE_ADDR_W{1'b0}};
			addr_ff <= {`SEE_ADDR_W{1'b0}};
			txByte_ff <= 8'h00;
		end else if (busy_ff) begin
			// inputs ignored during programming
			state_ff <= ST_IDLE;
			sdaOe_ff <= 1'b0;
			selected_ff <= 1'b0;
			pendWr_ff <= 1'b0;
		end else if (startCond) begin
			state_ff <= ST_DEV;
			bitCnt_ff <= 4'h0;
			ackPhase_ff <= 1'b0;
			sdaOe_ff <= 1'b0;
			pendWr_ff <= 1'b0;
		end else if (stopCond) begin
			state_ff <= ST_IDLE;
			sdaOe_ff <= 1'b0;
			selected_ff <= 1'b0;
			pendWr_ff <= 1'b0;
		end else begin
			case (state_ff)
			ST_IDLE: begin
				sdaOe_ff <= 1'b0;
			end
			ST_DEV: begin
				if (rxStep) begin
					shift_ff <= rxByte;
					bitCnt_ff <= bitCnt_ff + 4'h1;
				end
				if (byteDone) begin
					ackPhase_ff <= 1'b1;
					if (devMatch) begin
						sdaOut_ff <= 1'b0;
						sdaOe_ff <= 1'b1;
						selected_ff <= 1'b1;
						readDir_ff <= shift_ff[0];
					end else begin
						state_ff <= ST_HOLD;
					end
				end else if (ackDone) begin
					ackPhase_ff <= 1'b0;
					bitCnt_ff <= 4'h0;
					if (readDir_ff) begin
						// first data bit goes out on the fall ending the ack
						state_ff <= ST_RD;
						txByte_ff <= {memRdData[6:0], 1'b0};
						sdaOut_ff <= 1'b0;
						sdaOe_ff <= !memRdData[7];
						addr_ff <= rdNext;
					end else begin
						sdaOe_ff <= 1'b0;
						state_ff <= ST_WADR;
					end
				end
			end
			ST_WADR: begin
				if (rxStep) begin
					shift_ff <= rxByte;
					bitCnt_ff <= bitCnt_ff + 4'h1;
				end
				if (byteDone) begin
					ackPhase_ff <= 1'b1;
					sdaOut_ff <= 1'b0;
					sdaOe_ff <= 1'b1;
					addr_ff <= shift_ff[`SEE_ADDR_W-1:0];
				end else if (ackDone) begin
					ackPhase_ff <= 1'b0;
					bitCnt_ff <= 4'h0;
					sdaOe_ff <= 1'b0;
					state_ff <= ST_WDAT;
				end
			end
			ST_WDAT: begin
				if (rxStep) begin
					shift_ff <= rxByte;
					bitCnt_ff <= bitCnt_ff + 4'h1;
				end
				if (byteDone) begin
					// later bytes replace the pending one; stop commits it
					ackPhase_ff <= 1'b1;
					sdaOut_ff <= 1'b0;
					sdaOe_ff <= 1'b1;
					pendData_ff <= shift_ff;
					pendAddr_ff <= addr_ff;
					pendWr_ff <= fifoInReady;
					addr_ff <= wrNext;
				end else if (ackDone) begin
					ackPhase_ff <= 1'b0;
					bitCnt_ff <= 4'h0;
					sdaOe_ff <= 1'b0;
				end
			end
			ST_RD: begin
				if (sclFall) begin
					if (bitCnt_ff == `SEE_BIT_LAST - 4'h1) begin
						bitCnt_ff <= `SEE_BIT_LAST;
						sdaOe_ff <= !txByte_ff[7];
					end else if (bitCnt_ff == `SEE_BIT_LAST) begin
						sdaOe_ff <= 1'b0; // release for master ack
						state_ff <= ST_RACK;
					end else begin
						bitCnt_ff <= bitCnt_ff + 4'h1;
						sdaOe_ff <= !txByte_ff[7];
						txByte_ff <= {txByte_ff[6:0], 1'b0};
					end
				end
			end
			ST_RACK: begin
				if (sclRise) begin
					if (sdaSync)
						state_ff <= ST_HOLD;
					else
						ackPhase_ff <= 1'b1;
				end else if (sclFall && ackPhase_ff) begin
					ackPhase_ff <= 1'b0;
					bitCnt_ff <= 4'h0;
					state_ff <= ST_RD;
					txByte_ff <= {memRdData[6:0], 1'b0};
					sdaOut_ff <= 1'b0;
					sdaOe_ff <= !memRdData[7];
					addr_ff <= rdNext;
				end
			end
			ST_HOLD: begin
				sdaOe_ff <= 1'b0;
				selected_ff <= 1'b0;
			end
			default: begin
				state_ff <= ST_IDLE;
			end
			endcase
		end
	end
endmodule

// ===== see_slave_sva.sv
// assertions on the two-wire memory slave ports
`timescale 1ns/1ps
`include "see_defs.vh"
module see_slave_sva (
	// clock and reset
	input wire sys_clk,
	input wire sys_rst,
	// bus and status
	input wire sclIn,
	input wire sdaIn,
	input wire sdaOut_ff,
	input wire sdaOe_ff,
	input wire busy_ff,
	input wire selected_ff
);
	localparam int PMIN = `SEE_PROG_CYC - 2;
	localparam int PMAX = `SEE_PROG_CYC + 2;
	int busyCnt;
	always @(posedge sys_clk) begin
		if (sys_rst || !busy_ff) begin
			busyCnt <= 0;
		end else begin
			busyCnt <= busyCnt + 1;
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	a_drive_low: assert property (sdaOe_ff |-> !sdaOut_ff)
		else $error("driven high");
	a_reset_quiet: assert property ($fell(sys_rst) |->
		!sdaOe_ff && !busy_ff && !selected_ff) else $error("reset state");
	a_busy_no_ack: assert property (busy_ff |-> !sdaOe_ff)
		else $error("ack while busy");
	a_busy_deselect: assert property (busy_ff [*4] |-> !selected_ff)
		else $error("selected while busy");
	a_busy_length: assert property ($fell(busy_ff) |->
		busyCnt >= PMIN && busyCnt <= PMAX) else $error("busy length");
	a_change_fall: assert property (!$stable(sdaOe_ff) |->
		!$past(sclIn, 2)) else $error("change off fall");
	a_hold_high: assert property (sclIn && $past(sclIn) &&
		$past(sclIn, 2) |-> $stable(sdaOe_ff)) else $error("sda moved");
	a_select_ack: assert property ($rose(selected_ff) |->
		##[0:2] sdaOe_ff) else $error("select without ack");
	c_write: cover property ($fell(busy_ff));
	c_select: cover property ($rose(selected_ff));
	c_drive: cover property (selected_ff && sdaOe_ff && sclIn);
endmodule
bind see_slave see_slave_sva chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
	.sclIn(sclIn), .sdaIn(sdaIn), .sdaOut_ff(sdaOut_ff),
	.sdaOe_ff(sdaOe_ff), .busy_ff(busy_ff), .selected_ff(selected_ff));

// ===== tb_see_slave.sv
// self-checking bench for the two-wire memory slave
`timescale 1ns/1ps
`include "see_defs.vh"
module tb_see_slave;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic scl, sda, sdaOut, sdaOe, busy, selected, a;
	logic [7:0] d;
	int err_count = 0;
	int checks = 0;
	localparam logic [7:0] WR = {`SEE_DEV_ID, 1'b0};
	localparam logic [7:0] RD = {`SEE_DEV_ID, 1'b1};
	// open-drain wire with pull-up
	wire sdaLine = sda & ~sdaOe;
	initial forever #4 sys_clk = ~sys_clk;
	see_slave DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .sclIn(scl),
		.sdaIn(sdaLine), .sdaOut_ff(sdaOut), .sdaOe_ff(sdaOe),
		.busy_ff(busy), .selected_ff(selected));
	see_master_model m (.sdaLine(sdaLine), .scl(scl), .sda(sda));
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic stop_test();
		$display("errors %0d checks %0d", err_count, checks);
		if (err_count == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic addr(input logic [7:0] w);
		m.start();
		m.tx(WR, a);
		check(a, 0);
		m.tx(w, a);
		check(a, 0);
	endtask
	// byte write, then poll until the timed cycle ends
	task automatic write_byte(input logic [7:0] w, input logic [7:0] v);
		int n;
		addr(w);
		m.tx(v, a);
		check(a, 0);
		m.stop();
		#160;
		check(busy, 1);
		m.start();
		m.tx(WR, a);
		check(a, 1);
		n = 0;
		while (a !== 1'b0 && n < 20) begin
			m.start();
			m.tx(WR, a);
			n++;
		end
		check(a, 0);
		m.stop();
	endtask
	task automatic read_cur(input logic [7:0] e);
		m.start();
		m.tx(RD, a);
		check(a, 0);
		m.rx(1'b1, d);
		check(d, e);
		m.stop();
	endtask
	// random read crossing the array end
	task automatic read_wrap();
		addr(8'h7F);
		m.start();
		m.tx(RD, a);
		check(a, 0);
		m.rx(1'b0, d);
		check(d, 8'hA5);
		m.rx(1'b1, d);
		check(d, 8'h3C);
		m.stop();
	endtask
	task automatic wrong_dev();
		m.start();
		m.tx(8'hA2, a);
		check(a, 1);
		check(selected, 0);
		m.stop();
	endtask
	initial begin
		repeat (6) @(posedge sys_clk);
		sys_rst <= 1'b0;
		repeat (4) @(posedge sys_clk);
		check({sdaOe, busy, selected}, 0);
		write_byte(8'h7F, 8'hA5);
		write_byte(8'h00, 8'h3C);
		write_byte(8'h07, 8'h5A);
		read_cur(8'h3C);
		read_wrap();
		addr(8'h87);
		read_cur(8'h5A);
		wrong_dev();
		stop_test();
	end
	initial begin
		#200000;
		err_count++;
		stop_test();
	end
endmodule
